// >>> sim/serial_fiber_port_control_tb_top.sv
// Self-checking bench of the fiber port control block.
// Assumes sfp_pkg, the design, the far node and the checker are compiled.
`timescale 1ns/10ps
`default_nettype none
module serial_fiber_port_control_tb_top;
  import sfp_pkg::*;
  localparam int HOLD = 20;
  logic clk_i, rst_b_i, rx_light_i, rx_sync_i, rx_valid_i, rx_ready_o;
  logic rx_ctl_valid_i, blk_avail_i, loc_valid_i, loc_last_i, loc_ready_o;
  logic raw_valid_i, trigger_i, tx_valid_o, tx_en_o, rx_en_o;
  logic check_code_en_o, rate_fast_o, acq_halt_o, off;
  logic [31:0] reg_rdata_o, loc_data_i, raw_data_i, lfsr_ff, rd_v;
  logic [7:0] v;
  sfp_reg_req_t reg_req_i;
  sfp_word_t rx_word_i, tx_word_o, exp_q[$], tx_q[$];
  sfp_ctlbits_t rx_ctl_i;
  int n_mismatch, cmp_count;
  sfp_ctrl #(.HOLD_CYC(26'(HOLD))) u_dut (.clk_i, .rst_b_i, .reg_req_i,
    .reg_rdata_o, .rx_light_i, .rx_sync_i, .rx_word_i, .rx_valid_i,
    .rx_ready_o, .rx_ctl_i, .rx_ctl_valid_i, .blk_avail_i, .loc_data_i,
    .loc_valid_i, .loc_last_i, .loc_ready_o, .raw_data_i, .raw_valid_i,
    .trigger_i, .tx_word_o, .tx_valid_o, .tx_en_o, .rx_en_o,
    .check_code_en_o, .rate_fast_o, .acq_halt_o);
  sfp_far_node u_far (.clk_i, .rx_ready_i(rx_ready_o), .word_o(rx_word_i),
    .valid_o(rx_valid_i), .light_o(rx_light_i), .sync_o(rx_sync_i),
    .ctl_o(rx_ctl_i), .ctl_valid_o(rx_ctl_valid_i));
  function automatic logic [31:0] nxt_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic off_of(input logic [2:0] m);
    return !(m inside {3'h0, 3'h2, 3'h3, 3'h4});
  endfunction
  // Marker words carry no data worth comparing.
  function automatic logic [33:0] msk(input sfp_word_t w);
    return w.kind == SFP_KIND_DATA ? w : {w.kind, 32'h0};
  endfunction
  task automatic chk(input string nm, input logic [33:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_req_i <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    reg_req_i <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_req_i <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_i);
    reg_req_i <= '0;
    #1 rd_v = reg_rdata_o;
  endtask
  task automatic push_k(input sfp_kind_t k);
    exp_q.push_back('{k, 32'h0});
  endtask
  // Offers one local epoch, each word held until it is taken.
  task automatic loc_epoch(input int n);
    int k;
    @(posedge clk_i);
    blk_avail_i <= 1'b1;
    for (int i = 0; i < n; i++) begin
      lfsr_ff = nxt_lfsr(lfsr_ff);
      loc_data_i <= lfsr_ff;
      loc_valid_i <= 1'b1;
      loc_last_i <= i == n - 1;
      exp_q.push_back('{SFP_KIND_DATA, lfsr_ff});
      k = 0;
      do begin
        @(posedge clk_i);
        k++;
      end while (!loc_ready_o && k < 40);
    end
    loc_valid_i <= 1'b0;
    blk_avail_i <= 1'b0;
    loc_data_i <= ~loc_data_i;
  endtask
  // Streams raw samples; only kept ones are expected on the link.
  task automatic raw_burst(input int n, input logic keep);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      lfsr_ff = nxt_lfsr(lfsr_ff);
      raw_data_i <= lfsr_ff;
      raw_valid_i <= 1'b1;
      if (keep) exp_q.push_back('{SFP_KIND_DATA, lfsr_ff});
    end
    @(posedge clk_i);
    raw_valid_i <= 1'b0;
  endtask
  // Lets the link drain, then compares sent and expected words.
  task automatic cmp_tx();
    repeat (8) @(posedge clk_i);
    chk("tx count", tx_q.size(), exp_q.size());
    foreach (exp_q[i])
      if (i < tx_q.size())
        chk("tx word", msk(tx_q[i]), msk(exp_q[i]));
    tx_q.delete();
    exp_q.delete();
  endtask
  // Collects every word the block puts on the link.
  always @(posedge clk_i) if (tx_valid_o) tx_q.push_back(tx_word_o);
  // Free-running 100 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Watchdog at 100 us, some forty times the expected run length.
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
  // Main sequence of scenarios.
  initial begin
    {rst_b_i, blk_avail_i, loc_valid_i, loc_last_i, raw_valid_i} = '0;
    {trigger_i, loc_data_i, raw_data_i, reg_req_i} = '0;
    {n_mismatch, cmp_count} = '0;
    lfsr_ff = 32'h4274;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(8'h00);
    chk("ctrl reset", rd_v, 32'h10);
    chk("outs", {check_code_en_o, rate_fast_o}, 2'b10);
    rd(8'h10);
    chk("unmapped", rd_v, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      lfsr_ff = nxt_lfsr(lfsr_ff);
      exp_q.push_back('{SFP_KIND_DATA, lfsr_ff});
      u_far.send(SFP_KIND_DATA, lfsr_ff);
    end
    cmp_tx();
    rd(8'h04);
    chk("busy status", rd_v[4:0], 5'h17);
    repeat (HOLD + 4) @(posedge clk_i);
    rd(8'h04);
    chk("quiet status", rd_v[4:0], 5'h05);
    $display("test forward done");
    for (int c = 0; c < 8; c++) begin
      lfsr_ff = nxt_lfsr(lfsr_ff);
      v = {lfsr_ff[7:6], 1'b0, lfsr_ff[4], 1'b0, 3'(c)};
      off = off_of(v[2:0]);
      wr(8'h00, {24'h0, v});
      wr(8'h04, 32'h20);
      rd(8'h04);
      chk("enables", {tx_en_o, rx_en_o}, {!off, !off});
      chk("cfg outs", {check_code_en_o, rate_fast_o}, {v[4], v[6]});
      chk("halt", acq_halt_o, off && v[7]);
      chk("st", rd_v[6:5],
          {off && v[7], v[7] && c % 2 == 0 && c < 3});
      chk("tx on", rd_v[2], !off);
    end
    $display("test modes done");
    wr(8'h00, 32'h11);
    u_far.send_ctl(4'ha);
    u_far.send(SFP_KIND_DATA, lfsr_ff);
    cmp_tx();
    rd(8'h08);
    chk("ctl bits", rd_v[4:0], 5'h0a);
    u_far.link(1'b0, 1'b0);
    rd(8'h08);
    chk("no light", rd_v[4], 1'b1);
    rd(8'h04);
    chk("light bit", rd_v[0], 1'b0);
    u_far.link(1'b1, 1'b0);
    rd(8'h08);
    chk("no lock", rd_v[4], 1'b1);
    u_far.link(1'b1, 1'b1);
    $display("test disabled done");
    for (int j = 0; j < 3; j++) begin
      wr(8'h00, j == 0 ? 32'h3b : j == 1 ? 32'h33 : 32'h1b);
      loc_epoch(j + 2);
      push_k(SFP_KIND_EPOCH_END);
      if (j == 0) push_k(SFP_KIND_FRAME_START);
      cmp_tx();
    end
    rd(8'h04);
    chk("local traffic", rd_v[3], 1'b1);
    wr(8'h0c, 32'h1);
    push_k(SFP_KIND_FRAME_START);
    cmp_tx();
    $display("test source done");
    wr(8'h00, 32'h3c);
    lfsr_ff = nxt_lfsr(lfsr_ff);
    exp_q.push_back('{SFP_KIND_DATA, lfsr_ff});
    u_far.send(SFP_KIND_DATA, lfsr_ff);
    push_k(SFP_KIND_EPOCH_END);
    u_far.send(SFP_KIND_EPOCH_END, 32'h0);
    fork
      loc_epoch(2);
      u_far.send(SFP_KIND_FRAME_START, 32'h0);
    join
    push_k(SFP_KIND_EPOCH_END);
    push_k(SFP_KIND_FRAME_START);
    cmp_tx();
    $display("test chain done");
    wr(8'h00, 32'h12);
    raw_burst(3, 1'b0);
    @(posedge clk_i);
    trigger_i <= 1'b1;
    @(posedge clk_i);
    trigger_i <= 1'b0;
    raw_burst(3, 1'b1);
    wr(8'h00, 32'h10);
    raw_burst(2, 1'b0);
    cmp_tx();
    $display("test unfiltered done");
    test_done();
  end
endmodule // serial_fiber_port_control_tb_top
`default_nettype wire

// >>> sim/sfp_ctrl_asserts.sv
// Checker of the fiber port control block, bound to its top module.
// Assumes sfp_pkg is compiled first and every port shares clk_i.
`timescale 1ns/10ps
`default_nettype none
module sfp_ctrl_asserts #(
  parameter int CW = 26,
  parameter logic [CW-1:0] HOLD_CYC = '1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire sfp_pkg::sfp_reg_req_t reg_req_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic rx_light_i,
  input wire logic rx_sync_i,
  input wire sfp_pkg::sfp_word_t rx_word_i,
  input wire logic rx_valid_i,
  input wire logic rx_ready_o,
  input wire sfp_pkg::sfp_word_t tx_word_o,
  input wire logic tx_valid_o,
  input wire logic tx_en_o,
  input wire logic rx_en_o,
  input wire logic check_code_en_o,
  input wire logic rate_fast_o,
  input wire logic acq_halt_o
);
  import sfp_pkg::*;
  logic [7:0] ctrl_ff;
  logic off;
  logic rd_st;
  // Shadow of the control register, taken from the host writes.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) ctrl_ff <= 8'h10;
    else if (reg_req_i.wr && reg_req_i.addr == 8'h00)
      ctrl_ff <= reg_req_i.wdata[7:0];
  end
  // Unused mode codes count as the disabled mode.
  assign off = !(ctrl_ff[2:0] inside {3'h0, 3'h2, 3'h3, 3'h4});
  assign rd_st = reg_req_i.rd && reg_req_i.addr == 8'h04;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_epoch_end;
    tx_valid_o && tx_word_o.kind == SFP_KIND_EPOCH_END;
  endsequence
  sequence s_frame_start;
    tx_valid_o && tx_word_o.kind == SFP_KIND_FRAME_START;
  endsequence
  // Holds once the settings have stood still for one cycle.
  property p_settled(x);
    $stable(ctrl_ff) && $past(rst_b_i) |-> x;
  endproperty
  a_mode_enables: assert property (
    p_settled(tx_en_o == !off && rx_en_o == !off))
    else $error("link enables disagree with the mode");
  a_check_rate: assert property (
    p_settled(check_code_en_o == ctrl_ff[4] && rate_fast_o == ctrl_ff[6]))
    else $error("check code or rate output disagrees with setting");
  a_halt_paused: assert property (
    p_settled(acq_halt_o == (off && ctrl_ff[7])))
    else $error("acquisition halt disagrees with mode and destination");
  a_off_silent: assert property (
    p_settled(!(off && tx_valid_o)))
    else $error("link word sent in disabled mode");
  a_fwd_copy: assert property (
    ctrl_ff[2:0] == 3'h0 && rx_valid_i && rx_ready_o &&
    rx_word_i.kind == SFP_KIND_DATA
    |=> tx_valid_o && tx_word_o == $past(rx_word_i))
    else $error("forwarded word missing or changed");
  a_src_frame: assert property (
    (ctrl_ff[2:0] == 3'h3 && ctrl_ff[3] && ctrl_ff[5]) ##0 s_epoch_end
    |=> s_frame_start)
    else $error("no frame start right after epoch end");
  a_fault_read: assert property (
    reg_req_i.rd && reg_req_i.addr == 8'h08 && $stable(rx_light_i) &&
    $stable(rx_sync_i)
    |=> reg_rdata_o[4] == !($past(rx_light_i) && $past(rx_sync_i)))
    else $error("fault bit disagrees with light and lock");
  a_light_read: assert property (
    rd_st && $stable(rx_light_i) |=> reg_rdata_o[0] == $past(rx_light_i))
    else $error("light bit disagrees with the receiver");
  a_activity_or: assert property (
    rd_st |=> reg_rdata_o[4] == (reg_rdata_o[1] || reg_rdata_o[3]))
    else $error("activity flag is not the or of the traffic bits");
  a_conflict_seen: assert property (
    rd_st && $stable(ctrl_ff) && ctrl_ff[7] &&
    ctrl_ff[2:0] inside {3'h0, 3'h2} |=> reg_rdata_o[5])
    else $error("conflict flag clear while destination clashes");
endmodule // sfp_ctrl_asserts

bind sfp_ctrl sfp_ctrl_asserts #(.CW(CW), .HOLD_CYC(HOLD_CYC)) u_chk (
  .clk_i, .rst_b_i, .reg_req_i, .reg_rdata_o, .rx_light_i, .rx_sync_i,
  .rx_word_i, .rx_valid_i, .rx_ready_o, .tx_word_o, .tx_valid_o, .tx_en_o,
  .rx_en_o, .check_code_en_o, .rate_fast_o, .acq_halt_o
);
`default_nettype wire

// >>> sim/sfp_far_node.sv
// Far fiber node: light, lock, link words and embedded control bits.
// Assumes the bench calls its tasks and the block's ready is registered.
`timescale 1ns/10ps
`default_nettype none
module sfp_far_node (
  input wire logic clk_i,
  input wire logic rx_ready_i,
  output sfp_pkg::sfp_word_t word_o,
  output logic valid_o,
  output logic light_o,
  output logic sync_o,
  output sfp_pkg::sfp_ctlbits_t ctl_o,
  output logic ctl_valid_o
);
  import sfp_pkg::*;
  // Idle link with light present and the receiver locked.
  initial begin
    word_o = '0;
    valid_o = 1'b0;
    light_o = 1'b1;
    sync_o = 1'b1;
    ctl_o = '0;
    ctl_valid_o = 1'b0;
  end
  // Holds one word until it is taken, then shows garbage on the bus.
  task automatic send(input sfp_kind_t k, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    word_o <= '{k, d};
    valid_o <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (!rx_ready_i && n < 50);
    valid_o <= 1'b0;
    word_o <= ~word_o;
  endtask
  // Delivers one set of control bits for a single cycle.
  task automatic send_ctl(input sfp_ctlbits_t c);
    @(posedge clk_i);
    ctl_o <= c;
    ctl_valid_o <= 1'b1;
    @(posedge clk_i);
    ctl_valid_o <= 1'b0;
    ctl_o <= ~c;
  endtask
  // Changes light and lock; no lock is reported without light.
  task automatic link(input logic l, input logic s);
    @(posedge clk_i);
    light_o <= l;
    sync_o <= s && l;
  endtask
endmodule // sfp_far_node
`default_nettype wire

// >>> src/sfp_cfg.svh
// Offsets, field positions, reset values and timing figures of the fiber
// port control block.
// Assumes it is included by its bare name from the package and the top.
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

// Register byte offsets.
`define SFP_OFS_CTRL 8'h00
`define SFP_OFS_STATUS 8'h04
`define SFP_OFS_CTLBITS 8'h08
`define SFP_OFS_CMD 8'h0c

// Control register fields.
`define SFP_CTRL_MODE_LO 0
`define SFP_CTRL_MODE_HI 2
`define SFP_CTRL_AUTO_FS 3
`define SFP_CTRL_CHECK 4
`define SFP_CTRL_EPOCH 5
`define SFP_CTRL_RATE 6
`define SFP_CTRL_PORT_FIBER 7

// Status register fields.
`define SFP_ST_RX_LIGHT 0
`define SFP_ST_RX_TRAFFIC 1
`define SFP_ST_TX_ON 2
`define SFP_ST_TX_TRAFFIC 3
`define SFP_ST_ACTIVITY 4
`define SFP_ST_CONFLICT 5
`define SFP_ST_PAUSED 6

// Recovered control bit fields.
`define SFP_CB_PIO1 0
`define SFP_CB_PIO2 1
`define SFP_CB_DIR 2
`define SFP_CB_NRDY 3
`define SFP_CB_FAULT 4

// Command register fields.
`define SFP_CMD_FRAME_START 0

// Mode encodings; any other code acts as the disabled mode.
`define SFP_MODE_FORWARD 3'h0
`define SFP_MODE_DISABLED 3'h1
`define SFP_MODE_UNFILTERED 3'h2
`define SFP_MODE_SOURCE 3'h3
`define SFP_MODE_CHAIN_ADD 3'h4

// Reset values.
`define SFP_RST_MODE `SFP_MODE_FORWARD
`define SFP_RST_AUTO_FS 1'b0
`define SFP_RST_CHECK 1'b1
`define SFP_RST_EPOCH 1'b0
`define SFP_RST_RATE 1'b0
`define SFP_RST_PORT_FIBER 1'b0

// Activity hold interval and clock rate.
`define SFP_HOLD_MS 500
`define SFP_CLK_KHZ 100000

`endif

// >>> src/sfp_ctrl.sv
// Fiber port control: mode selection, link word multiplexing, activity
// indicators, control bit recovery and register port.
// Assumes all inputs are synchronous to clk_i and the host keeps its
// register strobes one cycle long and never both at once.
`timescale 1ns/10ps
`default_nettype none
`include "sfp_cfg.svh"

// Retriggerable hold counter; busy while the interval has not run out.
module sfp_hold_cnt #(
  parameter int CW = 26,
  parameter logic [CW-1:0] HOLD = '1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic kick_i,
  output logic busy_o
);
  logic [CW-1:0] cnt_ff;

  // Reload on every kick_i pulse, otherwise count down to zero.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_ff <= '0;
    end else if (kick_i) begin
      cnt_ff <= HOLD;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  assign busy_o = (cnt_ff != '0);
endmodule // sfp_hold_cnt

// Contract
// - Receive light indicator follows optical energy.
// - Receive traffic indicator held 500 ms.
// - Transmit enabled indicator while transmitter on.
// - Local transmit traffic indicator held 500 ms.
// - Activity flag when either lamp blinks.
// - Recover and expose embedded control bits.
// - Fault when no light or unsynchronised.
// - Source mode sends frame start after epoch.
// - Chain mode retransmits received epochs unchanged.
// - Chain mode inserts own epoch before frame start.
// - Auto frame start needs epoch generation, mode.
// - Auto default off; software frame starts pass.
// - One enable for check code both ways.
// - Unfiltered mode streams raw samples on link.
// - Disabled mode stops link, keeps control bits.
// - Disabled with fiber destination pauses acquisition.
// - Forward mode at reset copies received data.
// - Fiber destination in forward mode flags conflict.
// - Source mode sends filtered block when available.
// - Two link rates, default the slower one.
// - Unfiltered mode starts on trigger, ends on change.
module sfp_ctrl #(
  parameter int CW = 26,
  parameter logic [CW-1:0] HOLD_CYC =
    CW'(`SFP_HOLD_MS * (`SFP_CLK_KHZ))
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port.
  input wire sfp_pkg::sfp_reg_req_t reg_req_i,
  output logic [31:0] reg_rdata_o,
  // Receive side of the link.
  input wire logic rx_light_i,
  input wire logic rx_sync_i,
  input wire sfp_pkg::sfp_word_t rx_word_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  input wire sfp_pkg::sfp_ctlbits_t rx_ctl_i,
  input wire logic rx_ctl_valid_i,
  // Local filtered epoch source.
  input wire logic blk_avail_i,
  input wire logic [31:0] loc_data_i,
  input wire logic loc_valid_i,
  input wire logic loc_last_i,
  output logic loc_ready_o,
  // Raw converter samples and measurement trigger.
  input wire logic [31:0] raw_data_i,
  input wire logic raw_valid_i,
  input wire logic trigger_i,
  // Transmit side of the link and link settings.
  output sfp_pkg::sfp_word_t tx_word_o,
  output logic tx_valid_o,
  output logic tx_en_o,
  output logic rx_en_o,
  output logic check_code_en_o,
  output logic rate_fast_o,
  output logic acq_halt_o
);
  import sfp_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOCAL, ST_EPOCH_END, ST_FRAME_START, ST_RAW_WAIT, ST_RAW
  } sfp_state_t;

  sfp_state_t state_ff, nxt_state;
  logic [2:0] link_mode_ff;
  logic auto_frame_start_en_ff, check_code_en_ff, epoch_gen_en_ff;
  logic rate_fast_ff, port_fiber_ff;
  logic config_conflict_flag_ff, sw_fs_pend_ff, held_fs_ff, nxt_held_fs;
  logic [31:0] reg_rdata_ff;
  sfp_ctlbits_t ctl_ff;
  sfp_word_t tx_word_ff, nxt_tx_word;
  logic tx_valid_ff, nxt_tx_valid, tx_local_kick, sw_fs_sent;
  logic rx_ready_ff, loc_ready_ff, tx_en_ff, rx_en_ff, acq_halt_ff;
  logic rx_busy, tx_busy, rx_kick;
  logic m_fwd, m_off, m_raw, m_src, m_chain, auto_eff, link_fault_result;
  logic rx_take, loc_take, wr_ctrl, wr_status, wr_cmd;
  logic [31:0] st_word, cb_word;

  // Mode decode; unused codes fall into the disabled mode.
  assign m_fwd = (link_mode_ff == `SFP_MODE_FORWARD);
  assign m_raw = (link_mode_ff == `SFP_MODE_UNFILTERED);
  assign m_src = (link_mode_ff == `SFP_MODE_SOURCE);
  assign m_chain = (link_mode_ff == `SFP_MODE_CHAIN_ADD);
  assign m_off = !(m_fwd || m_raw || m_src || m_chain);

  // Auto frame starts act only with epoch generation in the right modes.
  assign auto_eff = auto_frame_start_en_ff && epoch_gen_en_ff &&
                    (m_src || m_chain);

  // Fault when light is missing or the receiver has not locked.
  assign link_fault_result = !rx_light_i || !rx_sync_i;

  assign rx_take = rx_valid_i && rx_ready_ff;
  assign loc_take = loc_valid_i && loc_ready_ff;

  // Register write decode.
  assign wr_ctrl = reg_req_i.wr && (reg_req_i.addr == `SFP_OFS_CTRL);
  assign wr_status = reg_req_i.wr && (reg_req_i.addr == `SFP_OFS_STATUS);
  assign wr_cmd = reg_req_i.wr && (reg_req_i.addr == `SFP_OFS_CMD);

  // Control register; the mode field resets to the forward mode.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      link_mode_ff <= `SFP_RST_MODE;
      auto_frame_start_en_ff <= `SFP_RST_AUTO_FS;
      check_code_en_ff <= `SFP_RST_CHECK;
      epoch_gen_en_ff <= `SFP_RST_EPOCH;
      rate_fast_ff <= `SFP_RST_RATE;
      port_fiber_ff <= `SFP_RST_PORT_FIBER;
    end else if (wr_ctrl) begin
      link_mode_ff <= reg_req_i.wdata[`SFP_CTRL_MODE_HI:`SFP_CTRL_MODE_LO];
      auto_frame_start_en_ff <= reg_req_i.wdata[`SFP_CTRL_AUTO_FS];
      check_code_en_ff <= reg_req_i.wdata[`SFP_CTRL_CHECK];
      epoch_gen_en_ff <= reg_req_i.wdata[`SFP_CTRL_EPOCH];
      rate_fast_ff <= reg_req_i.wdata[`SFP_CTRL_RATE];
      port_fiber_ff <= reg_req_i.wdata[`SFP_CTRL_PORT_FIBER];
    end
  end

  // Conflict flag: sticky, write one to clear, a new conflict wins.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      config_conflict_flag_ff <= 1'b0;
    end else if (port_fiber_ff && (m_fwd || m_raw)) begin
      config_conflict_flag_ff <= 1'b1;
    end else if (wr_status && reg_req_i.wdata[`SFP_ST_CONFLICT]) begin
      config_conflict_flag_ff <= 1'b0;
    end
  end

  // Software frame start request waits until a free transmit slot.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sw_fs_pend_ff <= 1'b0;
    end else if (wr_cmd && reg_req_i.wdata[`SFP_CMD_FRAME_START]) begin
      sw_fs_pend_ff <= 1'b1;
    end else if (sw_fs_sent) begin
      sw_fs_pend_ff <= 1'b0;
    end
  end

  // Control bits are captured in every mode, the disabled one included.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctl_ff <= '0;
    end else if (rx_ctl_valid_i) begin
      ctl_ff <= rx_ctl_i;
    end
  end

  // Link word sequencer.
  always_comb begin
    nxt_state = state_ff;
    nxt_held_fs = held_fs_ff;
    nxt_tx_word = '{kind: SFP_KIND_IDLE, data: 32'h0000_0000};
    nxt_tx_valid = 1'b0;
    tx_local_kick = 1'b0;
    sw_fs_sent = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (m_raw) begin
          nxt_state = ST_RAW_WAIT;
        end else if (m_src && blk_avail_i) begin
          nxt_state = ST_LOCAL;
        end else if ((m_fwd || m_chain) && rx_take) begin
          if (m_chain && rx_word_i.kind == SFP_KIND_FRAME_START &&
              loc_valid_i) begin
            nxt_held_fs = 1'b1;
            nxt_state = ST_LOCAL;
          end else if (m_chain && !auto_eff &&
                       rx_word_i.kind == SFP_KIND_FRAME_START) begin
            nxt_tx_valid = 1'b0;
          end else begin
            nxt_tx_word = rx_word_i;
            nxt_tx_valid = 1'b1;
          end
        end
        if (!nxt_tx_valid && nxt_state == ST_IDLE && sw_fs_pend_ff &&
            !m_off) begin
          nxt_tx_word.kind = SFP_KIND_FRAME_START;
          nxt_tx_valid = 1'b1;
          sw_fs_sent = 1'b1;
        end
      end
      ST_LOCAL: begin
        if (!(m_src || m_chain)) begin
          nxt_state = ST_IDLE;
          nxt_held_fs = 1'b0;
        end else if (loc_take) begin
          nxt_tx_word = '{kind: SFP_KIND_DATA, data: loc_data_i};
          nxt_tx_valid = 1'b1;
          tx_local_kick = 1'b1;
          if (loc_last_i) begin
            nxt_state = ST_EPOCH_END;
          end
        end
      end
      ST_EPOCH_END: begin
        nxt_tx_word.kind = SFP_KIND_EPOCH_END;
        nxt_tx_valid = 1'b1;
        if ((m_src && auto_eff) || (m_chain && held_fs_ff)) begin
          nxt_state = ST_FRAME_START;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      ST_FRAME_START: begin
        nxt_tx_word.kind = SFP_KIND_FRAME_START;
        nxt_tx_valid = auto_eff;
        nxt_held_fs = 1'b0;
        nxt_state = ST_IDLE;
      end
      ST_RAW_WAIT: begin
        if (!m_raw) begin
          nxt_state = ST_IDLE;
        end else if (trigger_i) begin
          nxt_state = ST_RAW;
        end
      end
      ST_RAW: begin
        if (!m_raw || link_fault_result) begin
          nxt_state = ST_IDLE;
        end else if (raw_valid_i) begin
          nxt_tx_word = '{kind: SFP_KIND_DATA, data: raw_data_i};
          nxt_tx_valid = 1'b1;
          tx_local_kick = 1'b1;
        end
      end
    endcase
  end

  // Sequencer state, link outputs and handshakes.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_ff <= ST_IDLE;
      held_fs_ff <= 1'b0;
      tx_word_ff <= '{kind: SFP_KIND_IDLE, data: 32'h0000_0000};
      tx_valid_ff <= 1'b0;
      rx_ready_ff <= 1'b0;
      loc_ready_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      held_fs_ff <= nxt_held_fs;
      tx_word_ff <= nxt_tx_word;
      tx_valid_ff <= nxt_tx_valid && !m_off;
      rx_ready_ff <= (nxt_state == ST_IDLE) || (nxt_state == ST_RAW_WAIT) ||
                     (nxt_state == ST_RAW);
      loc_ready_ff <= (nxt_state == ST_LOCAL) && !(loc_take && loc_last_i);
    end
  end

  // Link enables and acquisition pause.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tx_en_ff <= 1'b0;
      rx_en_ff <= 1'b0;
      acq_halt_ff <= 1'b0;
    end else begin
      tx_en_ff <= !m_off;
      rx_en_ff <= !m_off;
      acq_halt_ff <= m_off && port_fiber_ff;
    end
  end

  // Receive traffic counts only data words while the receiver is on.
  assign rx_kick = rx_valid_i && rx_en_ff &&
                   (rx_word_i.kind == SFP_KIND_DATA);

  // Hold counters behind the blinking indicators.
  sfp_hold_cnt #(.CW(CW), .HOLD(HOLD_CYC)) u_rx_hold (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .kick_i(rx_kick),
    .busy_o(rx_busy)
  );

  sfp_hold_cnt #(.CW(CW), .HOLD(HOLD_CYC)) u_tx_hold (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .kick_i(tx_local_kick && !m_off),
    .busy_o(tx_busy)
  );

  // Readable status and recovered control bit words.
  always_comb begin
    st_word = 32'h0000_0000;
    st_word[`SFP_ST_RX_LIGHT] = rx_light_i;
    st_word[`SFP_ST_RX_TRAFFIC] = rx_busy;
    st_word[`SFP_ST_TX_ON] = tx_en_ff;
    st_word[`SFP_ST_TX_TRAFFIC] = tx_busy;
    st_word[`SFP_ST_ACTIVITY] = rx_busy || tx_busy;
    st_word[`SFP_ST_CONFLICT] = config_conflict_flag_ff;
    st_word[`SFP_ST_PAUSED] = acq_halt_ff;
    cb_word = 32'h0000_0000;
    cb_word[`SFP_CB_PIO1] = ctl_ff.pio1;
    cb_word[`SFP_CB_PIO2] = ctl_ff.pio2;
    cb_word[`SFP_CB_DIR] = ctl_ff.dir;
    cb_word[`SFP_CB_NRDY] = ctl_ff.nrdy;
    cb_word[`SFP_CB_FAULT] = link_fault_result;
  end

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        `SFP_OFS_CTRL: begin
          reg_rdata_ff <= {24'h00_0000, port_fiber_ff, rate_fast_ff,
                           epoch_gen_en_ff, check_code_en_ff,
                           auto_frame_start_en_ff, link_mode_ff};
        end
        `SFP_OFS_STATUS: begin
          reg_rdata_ff <= st_word;
        end
        `SFP_OFS_CTLBITS: begin
          reg_rdata_ff <= cb_word;
        end
        default: begin
          reg_rdata_ff <= 32'h0000_0000;
        end
      endcase
    end else begin
      reg_rdata_ff <= 32'h0000_0000;
    end
  end

  assign reg_rdata_o = reg_rdata_ff;
  assign rx_ready_o = rx_ready_ff;
  assign loc_ready_o = loc_ready_ff;
  assign tx_word_o = tx_word_ff;
  assign tx_valid_o = tx_valid_ff;
  assign tx_en_o = tx_en_ff;
  assign rx_en_o = rx_en_ff;
  assign check_code_en_o = check_code_en_ff;
  assign rate_fast_o = rate_fast_ff;
  assign acq_halt_o = acq_halt_ff;
endmodule // sfp_ctrl
`default_nettype wire

// >>> src/sfp_pkg.sv
// Types shared by the fiber port control block and its surroundings.
// Assumes sfp_cfg.svh is on the include path.
`default_nettype none
`include "sfp_cfg.svh"

package sfp_pkg;

  // Kind of a word travelling on the link.
  typedef enum logic [1:0] {
    SFP_KIND_DATA = 2'h0,
    SFP_KIND_EPOCH_END = 2'h1,
    SFP_KIND_FRAME_START = 2'h2,
    SFP_KIND_IDLE = 2'h3
  } sfp_kind_t;

  // One link word with its kind.
  typedef struct packed {
    sfp_kind_t kind;
    logic [31:0] data;
  } sfp_word_t;

  // Control bits embedded in the serial stream.
  typedef struct packed {
    logic nrdy;
    logic dir;
    logic pio2;
    logic pio1;
  } sfp_ctlbits_t;

  // Host register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sfp_reg_req_t;

endpackage
`default_nettype wire
